/* logic/scl_entry_sync.sv */
// synchroniser and falling-edge detector for the serial entry inputs
`timescale 1ns/10ps
`default_nettype none
module scl_entry_sync
    import scl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ones,
    input wire logic i_zeros,
    input wire logic i_common,
    output logic o_fall_one,
    output logic o_fall_zero,
    output logic o_held,
    output logic o_common
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } scl_sync_t;

    scl_sync_t sync_r;
    scl_sync_t sync_nxt;

    always_comb begin
        sync_nxt = sync_r;
        sync_nxt.s1 = {i_common, i_zeros, i_ones};
        sync_nxt.s2 = sync_r.s1;
        sync_nxt.s3 = sync_r.s2;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    // entry counts on its return low, so a held level never repeats
    assign o_fall_one = sync_r.s3[0] & ~sync_r.s2[0];
    assign o_fall_zero = sync_r.s3[1] & ~sync_r.s2[1];
    assign o_held = sync_r.s2[0] | sync_r.s2[1];
    assign o_common = sync_r.s2[2];
endmodule
`default_nettype wire

/* logic/scl_lock.sv */
// serial code lock decoder with axi4-lite register slave
//
// Summary of operation
// - compare entries with nine-bit program code
// - first program input is first bit
// - open program input reads one, grounded zero
// - full code raises lock for window
// - held tenth entry keeps lock high
// - idle after reset, first entry activates
// - every entry restarts the timeout window
// - advance only if all earlier entries matched
// - token shifts through nine stages
// - after mismatch token frozen, window refreshed
// - error blocks until window expiry clears
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module scl_lock
    import scl_pkg::*;
#(
    parameter int unsigned P_TIMEOUT_CYC = SCL_TIMEOUT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [SCL_CODE_BITS-1:0] i_prog,
    input wire logic i_ones,
    input wire logic i_zeros,
    input wire logic i_common,
    output logic o_lock,
    output logic o_irq,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic awv;
        logic [7:0] awaddr;
        logic wv;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic manual;
        logic [31:0] tmo;
        logic [SCL_IRQ_BITS-1:0] ist;
        logic [SCL_IRQ_BITS-1:0] imsk;
        logic irq;
        logic active;
        logic err;
        logic lock;
        logic [SCL_TOK_BITS-1:0] tok;
        logic [31:0] tmr;
    } scl_state_t;

    scl_state_t st_r;
    scl_state_t st_nxt;

    logic fall_one;
    logic fall_zero;
    logic held;
    logic common;
    logic ent_one;
    logic ent_zero;
    logic ent;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // reference bit for the stage the token sits in
    function automatic logic exp_bit(input logic [SCL_TOK_BITS-1:0] tok,
                                     input logic [SCL_CODE_BITS-1:0] prog);
        logic b;
        b = 1'b0;
        for (int i = 0; i < SCL_CODE_BITS; i++) begin
            if (tok[i]) begin
                b = prog[i];
            end
        end
        return b;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        return (w == SCL_OFS_CTRL) || (w == SCL_OFS_TMO) || (w == SCL_OFS_STAT) ||
               (w == SCL_OFS_IST) || (w == SCL_OFS_IMSK) || (w == SCL_OFS_PROG);
    endfunction

    function automatic logic [31:0] strb(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                v[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // entry inputs
    // ------------------------------------------------------------
    scl_entry_sync u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ones(i_ones),
        .i_zeros(i_zeros),
        .i_common(i_common),
        .o_fall_one(fall_one),
        .o_fall_zero(fall_zero),
        .o_held(held),
        .o_common(common)
    );

    // manual switches only count while the common line is closed
    assign ent_one = fall_one & (~st_r.manual | common);
    assign ent_zero = fall_zero & (~st_r.manual | common);
    assign ent = ent_one | ent_zero;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] ra;
        logic [31:0] rd;
        logic [7:0] wa;
        ra = {i_araddr[7:2], 2'b00};
        rd = 32'h0000_0000;
        wa = {st_r.awaddr[7:2], 2'b00};
        st_nxt = st_r;
        // write channel
        if (st_r.bvalid && i_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (i_awvalid && st_r.awready) begin
            st_nxt.awv = 1'b1;
            st_nxt.awaddr = i_awaddr;
            wa = {i_awaddr[7:2], 2'b00};
        end
        if (i_wvalid && st_r.wready) begin
            st_nxt.wv = 1'b1;
            st_nxt.wdata = i_wdata;
            st_nxt.wstrb = i_wstrb;
        end
        if (st_nxt.awv && st_nxt.wv && !st_nxt.bvalid) begin
            st_nxt.awv = 1'b0;
            st_nxt.wv = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = addr_ok(wa) ? SCL_RESP_OKAY : SCL_RESP_SLVERR;
            if (wa == SCL_OFS_CTRL && st_nxt.wstrb[0]) begin
                st_nxt.manual = st_nxt.wdata[SCL_CTRL_MANUAL];
            end
            if (wa == SCL_OFS_TMO) begin
                st_nxt.tmo = strb(st_r.tmo, st_nxt.wdata, st_nxt.wstrb);
            end
            if (wa == SCL_OFS_IMSK && st_nxt.wstrb[0]) begin
                st_nxt.imsk = st_nxt.wdata[SCL_IRQ_BITS-1:0];
            end
        end
        st_nxt.awready = !st_nxt.awv && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.wv && !st_nxt.bvalid;
        // read channel; status clear comes before event sets below
        if (st_r.rvalid && i_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (i_arvalid && st_r.arready) begin
            case (ra)
                SCL_OFS_CTRL: rd[SCL_CTRL_MANUAL] = st_r.manual;
                SCL_OFS_TMO: rd = st_r.tmo;
                SCL_OFS_STAT: begin
                    rd[SCL_STAT_ACTIVE] = st_r.active;
                    rd[SCL_STAT_ERR] = st_r.err;
                    rd[SCL_STAT_LOCK] = st_r.lock;
                    rd[SCL_STAT_TOK +: SCL_TOK_BITS] = st_r.tok;
                end
                SCL_OFS_IST: begin
                    rd[SCL_IRQ_BITS-1:0] = st_r.ist;
                    st_nxt.ist = st_r.ist & ~st_r.ist;
                end
                SCL_OFS_IMSK: rd[SCL_IRQ_BITS-1:0] = st_r.imsk;
                SCL_OFS_PROG: rd[SCL_CODE_BITS-1:0] = i_prog;
                default: rd = 32'h0000_0000;
            endcase
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd;
            st_nxt.rresp = addr_ok(i_araddr) ? SCL_RESP_OKAY : SCL_RESP_SLVERR;
        end
        st_nxt.arready = !st_nxt.rvalid;
        // code comparison; an entry always wins over expiry
        if (ent) begin
            st_nxt.active = 1'b1;
            st_nxt.tmr = st_r.tmo;
            if (!st_r.err && !st_r.tok[SCL_CODE_BITS]) begin
                if (ent_one == exp_bit(st_r.tok, i_prog)) begin
                    st_nxt.tok = {st_r.tok[SCL_CODE_BITS-1:0], 1'b0};
                    if (st_r.tok[SCL_CODE_BITS-1]) begin
                        st_nxt.lock = 1'b1;
                        st_nxt.ist[SCL_IRQ_UNLOCK] = 1'b1;
                    end
                end else begin
                    st_nxt.err = 1'b1;
                    st_nxt.ist[SCL_IRQ_ERR] = 1'b1;
                end
            end
        end else if (st_r.lock && held) begin
            st_nxt.tmr = st_r.tmo;
        end else if (st_r.active) begin
            if (st_r.tmr <= 32'h0000_0001) begin
                // only a cycle with no entry, and no held input while locked, gets here
                st_nxt.active = 1'b0;
                st_nxt.err = 1'b0;
                st_nxt.lock = 1'b0;
                st_nxt.tok = SCL_TOK_RST;
                st_nxt.tmr = 32'h0000_0000;
                st_nxt.ist[SCL_IRQ_EXPIRE] = 1'b1;
            end else begin
                st_nxt.tmr = st_r.tmr - 32'h0000_0001;
            end
        end
        st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_r <= '0;
            st_r.tok <= SCL_TOK_RST;
            st_r.tmo <= 32'(P_TIMEOUT_CYC);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_lock = st_r.lock;
    assign o_irq = st_r.irq;
    assign o_awready = st_r.awready;
    assign o_wready = st_r.wready;
    assign o_bvalid = st_r.bvalid;
    assign o_bresp = st_r.bresp;
    assign o_arready = st_r.arready;
    assign o_rvalid = st_r.rvalid;
    assign o_rdata = st_r.rdata;
    assign o_rresp = st_r.rresp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    property p_adv;
        ent && !st_r.err && !st_r.tok[SCL_CODE_BITS] && (ent_one == exp_bit(st_r.tok, i_prog))
        |=> st_r.tok == {$past(st_r.tok[SCL_CODE_BITS-1:0]), 1'b0};
    endproperty
    a_adv: assert property (p_adv) else $error("token did not advance");

    property p_mis;
        ent && !st_r.err && !st_r.tok[SCL_CODE_BITS] && (ent_one != exp_bit(st_r.tok, i_prog))
        |=> st_r.err && $stable(st_r.tok);
    endproperty
    a_mis: assert property (p_mis) else $error("mismatch not caught");

    property p_frozen;
        st_r.err && ent |=> $stable(st_r.tok) && st_r.err;
    endproperty
    a_frozen: assert property (p_frozen) else $error("token moved in error");

    property p_reload;
        ent |=> st_r.tmr == $past(st_r.tmo) && st_r.active;
    endproperty
    a_reload: assert property (p_reload) else $error("window not restarted");

    property p_unlock;
        ent && !st_r.err && st_r.tok[SCL_CODE_BITS-1] && (ent_one == exp_bit(st_r.tok, i_prog))
        |=> o_lock ##1 o_lock;
    endproperty
    a_unlock: assert property (p_unlock) else $error("lock not raised");

    property p_keep;
        o_lock && (held || ent) |=> o_lock;
    endproperty
    a_keep: assert property (p_keep) else $error("held lock dropped");

    property p_expire;
        st_r.active && !ent && !(st_r.lock && held) && st_r.tmr <= 32'h0000_0001
        |=> !st_r.active && !st_r.err && !o_lock && st_r.tok == SCL_TOK_RST;
    endproperty
    a_expire: assert property (p_expire) else $error("expiry did not clear");

    property p_idle;
        !st_r.active |-> st_r.tok == SCL_TOK_RST && !st_r.err && !o_lock;
    endproperty
    a_idle: assert property (p_idle) else $error("idle state not clean");

    property p_onehot;
        $onehot(st_r.tok) && (st_r.tmr <= st_r.tmo || !st_r.active);
    endproperty
    a_onehot: assert property (p_onehot) else $error("token or timer corrupt");

    // tied to the pins themselves, so a broken synchroniser cannot hide behind it
    property p_fall;
        ent |-> $past(i_ones | i_zeros, 3) && (!st_r.manual || $past(i_common, 2));
    endproperty
    a_fall: assert property (p_fall) else $error("entry without falling edge");

    c_unlock: cover property (ent ##1 $rose(o_lock));
    c_error: cover property ($rose(st_r.err));
    c_expire: cover property ($fell(st_r.active) ##1 o_irq);
endmodule
`default_nettype wire

/* logic/scl_pkg.sv */
// constants and register map of the serial code lock decoder
package scl_pkg;
    // ------------------------------------------------------------
    // code and timing
    // ------------------------------------------------------------
    localparam int SCL_CODE_BITS = 9;
    localparam int SCL_TOK_BITS = SCL_CODE_BITS + 1;
    localparam logic [SCL_TOK_BITS-1:0] SCL_TOK_RST = 10'h001;
    localparam int SCL_CLK_KHZ = 25_000;
    localparam int SCL_TIMEOUT_MS = 1000;
    localparam int SCL_TIMEOUT_CYC = SCL_TIMEOUT_MS * SCL_CLK_KHZ;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] SCL_OFS_CTRL = 8'h00;
    localparam logic [7:0] SCL_OFS_TMO = 8'h04;
    localparam logic [7:0] SCL_OFS_STAT = 8'h08;
    localparam logic [7:0] SCL_OFS_IST = 8'h0C;
    localparam logic [7:0] SCL_OFS_IMSK = 8'h10;
    localparam logic [7:0] SCL_OFS_PROG = 8'h14;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int SCL_CTRL_MANUAL = 0;
    localparam int SCL_STAT_ACTIVE = 0;
    localparam int SCL_STAT_ERR = 1;
    localparam int SCL_STAT_LOCK = 2;
    localparam int SCL_STAT_TOK = 4;
    localparam int SCL_IRQ_BITS = 3;
    localparam int SCL_IRQ_UNLOCK = 0;
    localparam int SCL_IRQ_ERR = 1;
    localparam int SCL_IRQ_EXPIRE = 2;
    localparam logic [1:0] SCL_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCL_RESP_SLVERR = 2'h2;
endpackage

/* verif/scl_entry_src.sv */
// entry source model: two pushbuttons or a dual pulse train
`timescale 1ns/10ps
`default_nettype none
module scl_entry_src (
    input wire logic i_clk,
    output logic o_ones,
    output logic o_zeros,
    output logic o_common
);
    // ----
    // idle lines rest low through pull-downs
    // ----
    initial begin
        o_ones = 1'b0;
        o_zeros = 1'b0;
        o_common = 1'b0;
    end
    // one entry: press for hi cycles, release for lo cycles
    task automatic ent(input logic b, input int hi, input int lo);
        @(posedge i_clk);
        o_ones <= b;
        o_zeros <= ~b;
        repeat (hi) @(posedge i_clk);
        o_ones <= 1'b0;
        o_zeros <= 1'b0;
        // a long lo is inactivity, which lets the error logic clear
        repeat (lo) @(posedge i_clk);
    endtask
    // whole code in order, bit 0 first
    task automatic code(input logic [8:0] c);
        for (int i = 0; i < 9; i++) begin
            ent(c[i], 4, 4);
        end
    endtask
    // manual variant: third switch qualifies entries
    task automatic man(input logic c);
        @(posedge i_clk);
        o_common <= c;
    endtask
endmodule
`default_nettype wire

/* verif/scl_lock_test.sv */
// self-checking bench for the serial code lock decoder
`timescale 1ns/10ps
`default_nettype none
module scl_lock_test import scl_pkg::*;;
    // short window keeps the run brief
    localparam int P = 100;
    localparam logic [1:0] OK = SCL_RESP_OKAY;
    logic i_clk, i_rst_b, ones, zeros, common;
    logic [8:0] prog;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, o_rdata;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic o_lock, o_irq, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp;
    int err_total, compares;

    scl_lock #(.P_TIMEOUT_CYC(P)) uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_prog(prog),
        .i_ones(ones), .i_zeros(zeros), .i_common(common), .o_lock(o_lock), .o_irq(o_irq),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
        .o_bvalid(o_bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(rready));
    scl_entry_src src (.i_clk(i_clk), .o_ones(ones), .o_zeros(zeros), .o_common(common));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // ----
    // reporting
    // ----
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic stop_test;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----
    // bus cycles, entered just after a rising edge
    // ----
    task automatic wrr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge i_clk);
            if (o_awready) awvalid <= 1'b0;
            if (o_wready) wvalid <= 1'b0;
            if (o_bvalid) break;
        end
        if (n == 50) begin
            err_total++;
            stop_test();
        end
        chk(32'(o_bresp), 32'(e));
        bready <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rdr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge i_clk);
            if (o_arready) arvalid <= 1'b0;
            if (o_rvalid) break;
        end
        if (n == 50) begin
            err_total++;
            stop_test();
        end
        chk(o_rdata, d);
        chk(32'(o_rresp), 32'(e));
        rready <= 1'b0;
        @(posedge i_clk);
    endtask
    // bounded wait for the lock output to reach a level
    task automatic wlock(input logic e, input int m);
        int n;
        for (n = 0; n < m && o_lock !== e; n++) @(posedge i_clk);
        chk(32'(o_lock), 32'(e));
        if (o_lock !== e) stop_test();
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        i_rst_b = 1'b0;
        prog = 9'h0B5;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        err_total = 0;
        compares = 0;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk(32'(o_lock), 32'h0);
        rdr(SCL_OFS_CTRL, 32'h0, OK);
        rdr(SCL_OFS_TMO, P, OK);
        rdr(SCL_OFS_STAT, 32'h10, OK);
        rdr(SCL_OFS_PROG, {23'h0, prog}, OK);
        rdr(8'h18, 32'h0, SCL_RESP_SLVERR);
        wrr(8'h18, 32'h1, SCL_RESP_SLVERR);
        wrr(SCL_OFS_IMSK, 32'h7, OK);
        // full correct code, then window runs out
        src.code(prog);
        wlock(1'b1, 8);
        chk(32'(o_irq), 32'h1);
        rdr(SCL_OFS_STAT, 32'h2005, OK);
        rdr(SCL_OFS_IST, 32'h1, OK);
        repeat (2) @(posedge i_clk);
        chk(32'(o_irq), 32'h0);
        repeat (P - 35) @(posedge i_clk);
        chk(32'(o_lock), 32'h1);
        wlock(1'b0, 50);
        rdr(SCL_OFS_IST, 32'h4, OK);
        rdr(SCL_OFS_STAT, 32'h10, OK);
        // held tenth entry keeps the lock up past the window
        src.code(prog);
        wlock(1'b1, 8);
        src.ent(1'b0, 3 * P, 4);
        chk(32'(o_lock), 32'h1);
        wlock(1'b0, P + 20);
        rdr(SCL_OFS_IST, 32'h5, OK);
        // fifth bit wrong, slow entries keep refreshing the window
        for (int i = 0; i < 9; i++) begin
            src.ent(i == 4 ? ~prog[i] : prog[i], 4, P - 30);
        end
        chk(32'(o_lock), 32'h0);
        rdr(SCL_OFS_STAT, 32'h103, OK);
        repeat (P + 10) @(posedge i_clk);
        rdr(SCL_OFS_STAT, 32'h10, OK);
        rdr(SCL_OFS_IST, 32'h6, OK);
        src.code(prog);
        wlock(1'b1, 8);
        wlock(1'b0, P + 20);
        // manual mode: entries count only with common high
        prog <= 9'h14A;
        wrr(SCL_OFS_CTRL, 32'h1, OK);
        src.code(prog);
        chk(32'(o_lock), 32'h0);
        rdr(SCL_OFS_STAT, 32'h10, OK);
        // shorter window written at run time
        wrr(SCL_OFS_TMO, 32'h0000_0028, OK);
        rdr(SCL_OFS_TMO, 32'h0000_0028, OK);
        src.man(1'b1);
        src.code(prog);
        wlock(1'b1, 8);
        src.man(1'b0);
        repeat (30) @(posedge i_clk);
        chk(32'(o_lock), 32'h1);
        wlock(1'b0, 20);
        chk(32'(o_irq), 32'h1);
        // a cleared mask keeps the interrupt low while status stays pending
        wrr(SCL_OFS_IMSK, 32'h0000_0000, OK);
        chk(32'(o_irq), 32'h0);
        rdr(SCL_OFS_IST, 32'h0000_0005, OK);
        wrr(SCL_OFS_CTRL, 32'h0, OK);
        // byte strobes limit what lands
        wstrb <= 4'h2;
        wrr(SCL_OFS_TMO, 32'hFFFF_FFFF, OK);
        rdr(SCL_OFS_TMO, 32'h0000_FF28, OK);
        wrr(SCL_OFS_CTRL, 32'h1, OK);
        rdr(SCL_OFS_CTRL, 32'h0, OK);
        stop_test();
    end
endmodule
`default_nettype wire
